// ===== verilog/fsp_ctrl.sv
// Purpose: flash option, security, key and block protection control
// Assumes: nonvolatile option bytes and key are stable inputs from the array
// Notes on behaviour
// - Options register reloads from nonvolatile options byte at every reset.
// - Backdoor enable zero forbids unlocking by key comparison.
// - Key bytes accepted only from secure firmware, never from debug commands.
// - Matching eight key bytes in order unsecures until next reset.
// - Redirect-disable bit one disables vector redirection, zero permits it.
// - Only security code 1:0 means unsecured; all others secure.
// - While secure, unsecured sources including debug are blocked from memory.
// - Key match or full blank check forces working security code to 1:0.
// - Key access clear routes key-range writes to commands; set captures keys.
// - Protection register reloads from nonvolatile protection byte at reset.
// - Protection readable always; user writes ignored, debug writes allowed.
// - Enabled protection guards flash above boundary field bits 7:1.
// - Protection disable bit one turns all protection off.
// - Clearing key access after eight bytes triggers comparison.
// - Protected erase or program is dropped and sets violation flag.
`timescale 1ns/1ps
`include "fsp_consts.svh"
module fsp_ctrl
   import fsp_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Nonvolatile contents
   input wire logic [7:0] nv_options_byte,
   input wire logic [7:0] nv_protect_byte,
   input wire logic [63:0] backdoor_compare_key,
   // Register port
   input wire fsp_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // CPU write path
   input wire fsp_mem_wr_t mem_wr,
   input wire logic mem_req_unsecure_src,
   output logic mem_access_block,
   // Flash command path
   output fsp_cmd_t cmd_out,
   input wire logic blank_ok,
   // Status
   output logic secure,
   output logic vector_redirect_en
);
   initial begin
      if (ADDR_W != 16) $error("fsp_ctrl supports 16-bit addresses only");
   end

   // ==========================================
   // State
   logic [7:0] opt_r, opt_nxt;
   logic [7:0] prot_r, prot_nxt;
   logic key_write_access_r, key_write_access_nxt;
   logic viol_r, viol_nxt;
   logic loaded_r, loaded_nxt;
   logic [63:0] key_r, key_nxt;
   logic [2:0] kidx_r, kidx_nxt;
   logic korder_r, korder_nxt;
   fsp_kst_t kst_r, kst_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   fsp_cmd_t cmd_r, cmd_nxt;

   logic backdoor_enable, in_key_range, is_protected, match;
   logic [7:0] boundary_hi;

   // Decodes
   assign backdoor_enable = opt_r[`FSP_BIT_BACKDOOR_EN];
   assign vector_redirect_en = ~opt_r[`FSP_BIT_NORED];
   assign secure = (opt_r[1:0] != `FSP_SEC_UNSEC);
   assign mem_access_block = secure & mem_req_unsecure_src;
   assign in_key_range = (mem_wr.addr[15:3] == 13'(`FSP_KEY_BASE >> 3));
   // Boundary field sets upper address byte of last unprotected location
   assign boundary_hi = {prot_r[7:1], 1'b1};
   assign is_protected = ~prot_r[`FSP_BIT_PDIS] & (mem_wr.addr[15:8] > boundary_hi);
   assign match = (key_r == backdoor_compare_key);
   assign reg_rdata = rdata_r;
   assign cmd_out = cmd_r;

   // ==========================================
   // Next-state logic
   always_comb begin
      opt_nxt = opt_r;
      prot_nxt = prot_r;
      key_write_access_nxt = key_write_access_r;
      viol_nxt = viol_r;
      loaded_nxt = 1'b1;
      key_nxt = key_r;
      kidx_nxt = kidx_r;
      korder_nxt = korder_r;
      kst_nxt = kst_r;
      rdata_nxt = `FSP_ZERO8;
      cmd_nxt = '0;
      // Reset has cleared loaded_r; first clock after release takes the bytes
      if (!loaded_r) begin
         opt_nxt = nv_options_byte;
         prot_nxt = nv_protect_byte;
      end
      // Register writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            `FSP_OFS_CONFIG: begin
               key_write_access_nxt = reg_req.wdata[`FSP_BIT_KEY_ACCESS];
               if (reg_req.wdata[`FSP_BIT_KEY_ACCESS] && !key_write_access_r) begin
                  kst_nxt = FSP_K_LOAD;
                  kidx_nxt = '0;
                  korder_nxt = 1'b1;
               end
            end
            `FSP_OFS_PROTECT: begin
               if (reg_req.debug_cmd) prot_nxt = reg_req.wdata;
            end
            `FSP_OFS_STATUS: begin
               if (reg_req.wdata[`FSP_BIT_VIOL]) viol_nxt = 1'b0;
            end
            default: begin
            end
         endcase
      end
      // Key range writes: capture or forward as command
      if (mem_wr.wr && in_key_range && key_write_access_r) begin
         if (mem_wr.from_secure && !mem_wr.debug_cmd && kst_r == FSP_K_LOAD) begin
            key_nxt[8 * (7 - mem_wr.addr[2:0]) +: 8] = mem_wr.data;
            // Bytes must arrive in ascending order
            if (mem_wr.addr[2:0] != kidx_r) korder_nxt = 1'b0;
            if (kidx_r == `FSP_KEY_LAST) kst_nxt = FSP_K_DONE;
            kidx_nxt = kidx_r + 3'h1;
         end
      end else if (mem_wr.wr) begin
         if (is_protected) begin
            viol_nxt = 1'b1;
         end else begin
            cmd_nxt.addr = mem_wr.addr;
            cmd_nxt.data = mem_wr.data;
            cmd_nxt.valid = 1'b1;
         end
      end
      // Clearing key access ends entry and triggers the compare
      if (reg_req.wr && reg_req.addr == `FSP_OFS_CONFIG
          && !reg_req.wdata[`FSP_BIT_KEY_ACCESS] && key_write_access_r) begin
         if (kst_r == FSP_K_DONE && korder_r && match && backdoor_enable) begin
            opt_nxt[1:0] = `FSP_SEC_UNSEC;
         end
         kst_nxt = FSP_K_IDLE;
      end
      if (blank_ok) opt_nxt[1:0] = `FSP_SEC_UNSEC;
      // Register reads
      if (reg_req.rd) begin
         case (reg_req.addr)
            `FSP_OFS_OPTIONS: rdata_nxt = opt_r;
            `FSP_OFS_CONFIG: rdata_nxt = {2'b00, key_write_access_r, 5'b00000};
            `FSP_OFS_PROTECT: rdata_nxt = prot_r;
            `FSP_OFS_STATUS: rdata_nxt = {2'b00, viol_r, 4'h0, ~secure};
            default: rdata_nxt = `FSP_ZERO8;
         endcase
      end
   end

   // Register stage; the set of the violation flag wins over a same-cycle clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         opt_r <= `FSP_ZERO8;
         prot_r <= `FSP_ZERO8;
         key_write_access_r <= 1'b0;
         viol_r <= 1'b0;
         loaded_r <= 1'b0;
         key_r <= '0;
         kidx_r <= '0;
         korder_r <= 1'b0;
         kst_r <= FSP_K_IDLE;
         rdata_r <= `FSP_ZERO8;
         cmd_r <= '0;
      end else begin
         opt_r <= opt_nxt;
         prot_r <= prot_nxt;
         key_write_access_r <= key_write_access_nxt;
         viol_r <= viol_nxt;
         loaded_r <= loaded_nxt;
         key_r <= key_nxt;
         kidx_r <= kidx_nxt;
         korder_r <= korder_nxt;
         kst_r <= kst_nxt;
         rdata_r <= rdata_nxt;
         cmd_r <= cmd_nxt;
      end
   end
endmodule

// ===== verilog/fsp_consts.svh
// Purpose: constants for the flash security and protection option block
// Assumes: 8-bit registers on a plain word-indexed register port
// Notes: offsets are register indices on the local port
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH
// ==========================================
// Register offsets
`define FSP_OFS_OPTIONS 4'h0
`define FSP_OFS_CONFIG 4'h1
`define FSP_OFS_PROTECT 4'h2
`define FSP_OFS_STATUS 4'h3
// ==========================================
// Field positions
`define FSP_BIT_BACKDOOR_EN 7
`define FSP_BIT_NORED 6
`define FSP_BIT_KEY_ACCESS 5
`define FSP_BIT_PDIS 0
`define FSP_BIT_VIOL 5
`define FSP_BIT_UNSEC 0
// ==========================================
// Values
`define FSP_SEC_UNSEC 2'h2
`define FSP_KEY_BASE 16'hFFB0
`define FSP_KEY_LAST 3'h7
`define FSP_ZERO8 8'h00
`endif

// ===== verilog/fsp_pkg.sv
// Purpose: shared types for the flash security and protection option block
// Assumes: none
// Notes: types only; numbers live in fsp_consts.svh
package fsp_pkg;
   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic debug_cmd;
   } fsp_reg_req_t;
   // CPU write seen on the memory bus
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic wr;
      logic from_secure;
      logic debug_cmd;
   } fsp_mem_wr_t;
   // Flash command request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic valid;
   } fsp_cmd_t;
   // Key engine states
   typedef enum logic [1:0] {
      FSP_K_IDLE = 2'b00,
      FSP_K_LOAD = 2'b01,
      FSP_K_DONE = 2'b10
   } fsp_kst_t;
endpackage

// ===== bench/fsp_ctrl_monitor.sv
// Purpose: port checker for the flash option, security and protection block
// Assumes: nonvolatile bytes change only while reset is held
// Notes: bound to fsp_ctrl at the foot of this file
`timescale 1ns/1ps
`include "fsp_consts.svh"
module fsp_ctrl_monitor
   import fsp_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock, reset and inputs
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] nv_options_byte,
   input wire fsp_reg_req_t reg_req,
   input wire fsp_mem_wr_t mem_wr,
   input wire logic mem_req_unsecure_src,
   input wire logic blank_ok,
   // Outputs
   input wire logic [7:0] reg_rdata,
   input wire logic mem_access_block,
   input wire fsp_cmd_t cmd_out,
   input wire logic secure,
   input wire logic vector_redirect_en
);
   // ====================================
   // Properties, one clock domain
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Load edge is the first after release, so look two edges back
   property p_load;
      $past(rst_b) && !$past(rst_b, 2) |-> secure == (nv_options_byte[1:0] != `FSP_SEC_UNSEC);
   endproperty
   property p_fall;
      $fell(secure) && $past(rst_b, 2) |-> $past(blank_ok) || $past(reg_req.wr);
   endproperty
   property p_rise;
      $past(rst_b, 2) |-> !$rose(secure);
   endproperty
   property p_blank;
      $past(rst_b) && blank_ok |=> !secure;
   endproperty
   property p_redir;
      $past(rst_b) |-> vector_redirect_en == !nv_options_byte[6];
   endproperty
   property p_block;
      mem_access_block == (secure && mem_req_unsecure_src);
   endproperty
   property p_rdata;
      reg_rdata != 8'h00 |-> $past(reg_req.rd);
   endproperty
   property p_cmd;
      cmd_out.valid |-> $past(mem_wr.wr) && cmd_out.addr == $past(mem_wr.addr);
   endproperty
   a_load: assert property (p_load) else $error("security state wrong after load");
   a_fall: assert property (p_fall) else $error("unlock without a cause");
   a_rise: assert property (p_rise) else $error("relock outside reset");
   a_blank: assert property (p_blank) else $error("blank check did not unlock");
   a_redir: assert property (p_redir) else $error("redirect enable wrong");
   a_block: assert property (p_block) else $error("memory block wrong");
   a_rdata: assert property (p_rdata) else $error("read data without read");
   a_cmd: assert property (p_cmd) else $error("command without write");
   c_unlock: cover property ($fell(secure));
   c_cmd: cover property (cmd_out.valid);
   c_read: cover property (reg_rdata != 8'h00);
endmodule
bind fsp_ctrl fsp_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk(clk), .rst_b(rst_b),
   .nv_options_byte(nv_options_byte), .reg_req(reg_req), .mem_wr(mem_wr),
   .mem_req_unsecure_src(mem_req_unsecure_src), .blank_ok(blank_ok), .reg_rdata(reg_rdata),
   .mem_access_block(mem_access_block), .cmd_out(cmd_out), .secure(secure),
   .vector_redirect_en(vector_redirect_en));

// ===== bench/tb_top.sv
// Purpose: directed bench for the flash option, security and protection block
// Assumes: 20 MHz clock, read data stand one cycle after the strobe
// Notes: a gap cycle follows every bus request to keep strobes single
`timescale 1ns/1ps
`include "fsp_consts.svh"
module tb_top;
   import fsp_pkg::*;
   localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] nv_opt = 8'hC3;
   logic [7:0] nv_prot = 8'hFF;
   fsp_reg_req_t rq = '0;
   fsp_mem_wr_t mw = '0;
   logic blank = 1'b0;
   logic unsrc = 1'b1;
   logic [7:0] rdata;
   logic blk, sec, redir;
   fsp_cmd_t cmd;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   // ====================================
   // Design, clock and hang guard
   fsp_ctrl u_fsp_ctrl (.clk(clk), .rst_b(rst_b), .nv_options_byte(nv_opt),
      .nv_protect_byte(nv_prot), .backdoor_compare_key(KEY), .reg_req(rq), .reg_rdata(rdata),
      .mem_wr(mw), .mem_req_unsecure_src(unsrc), .mem_access_block(blk), .cmd_out(cmd),
      .blank_ok(blank), .secure(sec), .vector_redirect_en(redir));
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end
   // ====================================
   // Bus tasks
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
      rst_b <= 1'b0;
      nv_opt <= o;
      nv_prot <= p;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d, input logic dbg);
      rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, debug_cmd: dbg};
      @(posedge clk);
      rq.wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
      rq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, debug_cmd: 1'b0};
      @(posedge clk);
      rq.rd <= 1'b0;
      #1 chk("read", exp, rdata);
      @(posedge clk);
   endtask
   // Debug writes are never from secure memory
   task automatic mwr(input logic [15:0] a, input logic [7:0] d, input logic dbg, input logic v);
      mw <= '{addr: a, data: d, wr: 1'b1, from_secure: !dbg, debug_cmd: dbg};
      @(posedge clk);
      mw.wr <= 1'b0;
      #1 chk("cmd valid", 8'(v), 8'(cmd.valid));
      chk("cmd data", v ? d : 8'h00, cmd.data);
      chk("cmd addr", v ? a[15:8] : 8'h00, cmd.addr[15:8]);
      @(posedge clk);
   endtask
   // ====================================
   // Scenarios
   task automatic t_load();
      logic [7:0] o;
      for (int i = 0; i < 4; i++) begin
         o = 8'(i) | (i[0] ? 8'h40 : 8'h00);
         do_reset(o, 8'(8'h35 + i));
         rreg(`FSP_OFS_OPTIONS, o);
         rreg(`FSP_OFS_PROTECT, 8'(8'h35 + i));
         chk("secure", 8'(i != 2), 8'(sec));
         chk("redirect", 8'(!o[6]), 8'(redir));
      end
   endtask
   task automatic t_prot();
      do_reset(8'hC3, 8'hFF);
      unsrc <= 1'b0;
      @(posedge clk);
      #1 chk("block", 8'h00, 8'(blk));
      unsrc <= 1'b1;
      @(posedge clk);
      #1 chk("block", 8'h01, 8'(blk));
      @(posedge clk);
      wreg(`FSP_OFS_PROTECT, 8'h80, 1'b0);
      rreg(`FSP_OFS_PROTECT, 8'hFF);
      wreg(`FSP_OFS_PROTECT, 8'h80, 1'b1);
      rreg(`FSP_OFS_PROTECT, 8'h80);
      mwr(16'h9000, 8'h55, 1'b0, 1'b0);
      rreg(`FSP_OFS_STATUS, 8'h20);
      wreg(`FSP_OFS_STATUS, 8'h20, 1'b0);
      rreg(`FSP_OFS_STATUS, 8'h00);
      mwr(16'h8100, 8'h55, 1'b0, 1'b1);
      wreg(`FSP_OFS_PROTECT, 8'h81, 1'b1);
      mwr(16'h9000, 8'h55, 1'b0, 1'b1);
      mwr(`FSP_KEY_BASE, 8'h55, 1'b0, 1'b1);
      rreg(4'hF, 8'h00);
   endtask
   // Key bytes go in ascending order with an idle cycle between them
   task automatic t_key(input logic [7:0] o, input logic dbg, input logic bad, input logic e);
      do_reset(o, 8'hFF);
      wreg(`FSP_OFS_CONFIG, 8'h20, 1'b0);
      rreg(`FSP_OFS_CONFIG, 8'h20);
      for (int i = 0; i < 8; i++) begin
         mwr(`FSP_KEY_BASE + 16'(i), KEY[63-8*i -: 8] ^ 8'(bad && i == 7), dbg, 1'b0);
      end
      wreg(`FSP_OFS_CONFIG, 8'h00, 1'b0);
      chk("secure", 8'(e), 8'(sec));
      chk("block", 8'(e), 8'(blk));
   endtask
   task automatic t_blank();
      do_reset(8'hC3, 8'hFF);
      blank <= 1'b1;
      @(posedge clk);
      blank <= 1'b0;
      @(posedge clk);
      chk("secure", 8'h00, 8'(sec));
      rreg(`FSP_OFS_STATUS, 8'h01);
      do_reset(8'hC3, 8'hFF);
      chk("secure", 8'h01, 8'(sec));
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      t_load();
      t_prot();
      t_key(8'hC3, 1'b0, 1'b0, 1'b0);
      t_key(8'h43, 1'b0, 1'b0, 1'b1);
      t_key(8'hC3, 1'b1, 1'b0, 1'b1);
      t_key(8'hC3, 1'b0, 1'b1, 1'b1);
      t_blank();
      stop_test();
   end
endmodule
